// [verilog/rtc_core.v]
// Resistance converter trigger, configuration and pulse routing control with an APB register slave.
// Assumes a 40 MHz clock; pins arrive asynchronously, cap_done_i comes from same-clock logic.
//
// Behaviour
// - Phase lasts one or two oscillator periods
// - Guard amp current trim field, advise 7
// - Pre-divider passes every Nth trigger
// - Pre-divider also divides oscillator timer trigger
// - Trigger source: off, timer, pin, capacitance end
// - Sources 5,6 start on capacitance end
// - Averaging none, four, eight, sixteen samples
// - Port enable bits activate ref, sensor
// - Bit enables on-chip aluminium sensor
// - Bit enables on-chip reference resistor
// - Warm-up runs two or eight discarded
// - Two-bit field picks trigger gpio pin
// - Debounce field 3 enables mono-flop filter
// - Speed field sets dsp clock rate
// - Bit routes pulse to pin 3/1
// - Bit routes pulse to pin 2/0
//
// Chosen here: the APB slave port.
`include "rtc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
	// Clock and reset
	input wire clock_i,
	input wire resetn_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// Pins and converter events
	input wire [3:0] gpio_pin_i,
	input wire cap_done_i,
	input wire dsp_pulse_i,
	// Converter control
	output reg rdc_phase_o,
	output reg rdc_sample_valid_o,
	output reg rdc_result_valid_o,
	output reg ref_resistor_port_o,
	output reg sensor_resistor_port_o,
	output reg onchip_sensor_o,
	output reg onchip_ref_resistor_o,
	output reg [2:0] guard_amp_current_trim_o,
	output reg [1:0] dsp_speed_o,
	output reg dsp_clk_en_o,
	output reg [3:0] gpio_pulse_o,
	output reg [3:0] internal_timing_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] rdc_cycle_guard_trim;
	reg [7:0] rdc_divider_low;
	reg [7:0] rdc_trigger_average;
	reg [7:0] rdc_port_warmup_pin;
	reg [7:0] converter_internal_a;
	reg [7:0] converter_internal_b;
	reg [7:0] converter_internal_c;
	reg [7:0] dsp_speed_pin_routing;
	reg busy;

	wire rdc_cycle_double = rdc_cycle_guard_trim[7];
	wire [9:0] prediv = {rdc_trigger_average[1:0], rdc_divider_low};
	wire [2:0] trig_sel = rdc_trigger_average[6:4];
	wire [1:0] rdc_average_count = rdc_trigger_average[3:2];
	wire [1:0] rdc_start_pin_select = rdc_port_warmup_pin[1:0];
	wire warm_long = rdc_port_warmup_pin[2];
	wire [1:0] pulse_debounce_enable = dsp_speed_pin_routing[7:6];
	wire pulse_route_pin_b = dsp_speed_pin_routing[1];
	wire pulse_route_pin_a = dsp_speed_pin_routing[0];
	function [7:0] idx_of;
		input [31:0] addr;
		begin
			idx_of = addr[9:2];
		end
	endfunction
	wire [7:0] idx = idx_of(paddr_i);
	wire access = psel_i & penable_i & pready_o;
	// Upper address bits must be clear, otherwise high addresses would alias onto the registers
	wire mapped = (idx >= `RTC_IDX_CYCLE) && (idx <= `RTC_IDX_STATUS) && (paddr_i[1:0] == 2'b00)
		&& (paddr_i[31:10] == 22'h000000);
	// ----------------------------------------
	// APB slave: one wait state per access
	// ----------------------------------------
	reg [7:0] rd_byte;
	always @* begin
		case (idx)
			`RTC_IDX_CYCLE: rd_byte = rdc_cycle_guard_trim;
			`RTC_IDX_DIVLO: rd_byte = rdc_divider_low;
			`RTC_IDX_TRIG: rd_byte = rdc_trigger_average;
			`RTC_IDX_PORT: rd_byte = rdc_port_warmup_pin;
			`RTC_IDX_INTA: rd_byte = converter_internal_a;
			`RTC_IDX_INTB: rd_byte = converter_internal_b;
			`RTC_IDX_INTC: rd_byte = converter_internal_c;
			`RTC_IDX_DSP: rd_byte = dsp_speed_pin_routing;
			`RTC_IDX_STATUS: rd_byte = {7'h00, busy};
			default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i & penable_i & ~pready_o;
			if (psel_i & penable_i & ~pready_o) begin
				pslverr_o <= ~mapped;
				prdata_o <= (mapped & ~pwrite_i) ? {24'h000000, rd_byte} : 32'h00000000;
			end
		end
	end
	wire wr = access & pwrite_i & mapped;
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdc_cycle_guard_trim <= 8'h07;
			rdc_divider_low <= 8'h00;
			rdc_trigger_average <= 8'h00;
			rdc_port_warmup_pin <= 8'h00;
			converter_internal_a <= 8'h00;
			converter_internal_b <= 8'h00;
			converter_internal_c <= 8'h00;
			dsp_speed_pin_routing <= 8'h08;
		end else if (wr) begin
			case (idx)
				`RTC_IDX_CYCLE: rdc_cycle_guard_trim <= {pwdata_i[7], 4'h0, pwdata_i[2:0]};
				`RTC_IDX_DIVLO: rdc_divider_low <= pwdata_i[7:0];
				`RTC_IDX_TRIG: rdc_trigger_average <= {1'b0, pwdata_i[6:0]};
				`RTC_IDX_PORT: rdc_port_warmup_pin <= {pwdata_i[7:4], 1'b0, pwdata_i[2:0]};
				// Stored with their reserved bits cleared; only the fixed values are meaningful
				`RTC_IDX_INTA: converter_internal_a <= {2'b00, pwdata_i[5:0]};
				`RTC_IDX_INTB: converter_internal_b <= {pwdata_i[7:2], 2'b00};
				`RTC_IDX_INTC: converter_internal_c <= {pwdata_i[7:1], 1'b0};
				`RTC_IDX_DSP: dsp_speed_pin_routing <= {pwdata_i[7:6], 2'b00, pwdata_i[3:0]};
				default: rdc_divider_low <= rdc_divider_low;
			endcase
		end
	end

	// ----------------------------------------
	// Pin synchronisers, change counts when stages 2 and 3 agree
	// ----------------------------------------
	reg [3:0] pin_s1, pin_s2, pin_s3, pin_q;
	reg dsp_s1, dsp_s2, dsp_s3, dsp_q;
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
			pin_q <= 4'h0;
			dsp_s1 <= 1'b0;
			dsp_s2 <= 1'b0;
			dsp_s3 <= 1'b0;
			dsp_q <= 1'b0;
		end else begin
			pin_s1 <= gpio_pin_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
			dsp_s1 <= dsp_pulse_i;
			dsp_s2 <= dsp_s1;
			dsp_s3 <= dsp_s2;
			if (dsp_s2 == dsp_s3)
				dsp_q <= dsp_s2;
		end
	end

	// ----------------------------------------
	// Low-frequency oscillator enable
	// ----------------------------------------
	reg [15:0] lfo_cnt;
	wire lfo_tick = (lfo_cnt == 16'h0000);
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			lfo_cnt <= 16'h0000;
		else if (lfo_tick)
			lfo_cnt <= `RTC_LFO_DIV - 16'h0001;
		else
			lfo_cnt <= lfo_cnt - 16'h0001;
	end
	// ----------------------------------------
	// Trigger selection and pre-divider
	// ----------------------------------------
	wire [9:0] div_top = (prediv < 10'h002) ? 10'h001 : prediv;
	reg [9:0] tmr_cnt;
	reg timer_trig;
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tmr_cnt <= 10'h000;
			timer_trig <= 1'b0;
		end else begin
			timer_trig <= 1'b0;
			if (lfo_tick) begin
				if (tmr_cnt + 10'h001 >= div_top) begin
					tmr_cnt <= 10'h000;
					timer_trig <= 1'b1;
				end else
					tmr_cnt <= tmr_cnt + 10'h001;
			end
		end
	end

	reg pin_prev;
	wire pin_sel = pin_q[rdc_start_pin_select];
	wire pin_rise = pin_sel & ~pin_prev;
	reg raw_trig;
	always @* begin
		case (trig_sel)
			`RTC_TRIG_TIMER: raw_trig = timer_trig;
			`RTC_TRIG_PIN: raw_trig = pin_rise;
			`RTC_TRIG_CAP_ASYNC: raw_trig = cap_done_i;
			`RTC_TRIG_CAP_SYNC: raw_trig = cap_done_i;
			default: raw_trig = 1'b0;
		endcase
	end
	// Timer source is already divided, so it bypasses the event pre-divider
	wire need_div = (trig_sel != `RTC_TRIG_TIMER);
	reg [9:0] ev_cnt;
	reg start;
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_prev <= 1'b0;
			ev_cnt <= 10'h000;
			start <= 1'b0;
		end else begin
			pin_prev <= pin_sel;
			start <= 1'b0;
			if (raw_trig) begin
				if (!need_div || ev_cnt + 10'h001 >= div_top) begin
					ev_cnt <= 10'h000;
					start <= 1'b1;
				end else
					ev_cnt <= ev_cnt + 10'h001;
			end
		end
	end

	// ----------------------------------------
	// Measurement sequencer; starts while busy are dropped
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	reg [1:0] state;
	reg [1:0] phase;
	reg phase_half;
	reg [4:0] sample_cnt;
	wire [4:0] warm_n = warm_long ? `RTC_WARM_LONG : `RTC_WARM_SHORT;
	reg [4:0] avg_n;
	always @* begin
		case (rdc_average_count)
			2'd1: avg_n = 5'd4;
			2'd2: avg_n = 5'd8;
			2'd3: avg_n = 5'd16;
			default: avg_n = 5'd1;
		endcase
	end
	wire [5:0] total_n = {1'b0, warm_n} + {1'b0, avg_n};
	wire phase_end = lfo_tick & (phase_half | ~rdc_cycle_double);

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_IDLE;
			phase <= 2'd0;
			phase_half <= 1'b0;
			sample_cnt <= 5'd0;
			busy <= 1'b0;
			rdc_phase_o <= 1'b0;
			rdc_sample_valid_o <= 1'b0;
			rdc_result_valid_o <= 1'b0;
		end else begin
			rdc_sample_valid_o <= 1'b0;
			rdc_result_valid_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_RUN;
						busy <= 1'b1;
						phase <= 2'd0;
						phase_half <= 1'b0;
						sample_cnt <= 5'd0;
						rdc_phase_o <= 1'b1;
					end
				end
				ST_RUN: begin
					if (lfo_tick)
						phase_half <= ~phase_half & rdc_cycle_double;
					if (phase_end) begin
						if (phase == 2'd2) begin
							phase <= 2'd0;
							rdc_sample_valid_o <= (sample_cnt >= warm_n);
							if ({1'b0, sample_cnt} + 6'd1 >= total_n) begin
								state <= ST_IDLE;
								busy <= 1'b0;
								rdc_phase_o <= 1'b0;
								rdc_result_valid_o <= 1'b1;
							end else
								sample_cnt <= sample_cnt + 5'd1;
						end else
							phase <= phase + 2'd1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Port enables, dsp speed and pulse routing
	// ----------------------------------------
	reg [7:0] deb_cnt;
	reg pulse_f;
	reg [1:0] spd_cnt;
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_resistor_port_o <= 1'b0;
			sensor_resistor_port_o <= 1'b0;
			onchip_sensor_o <= 1'b0;
			onchip_ref_resistor_o <= 1'b0;
			guard_amp_current_trim_o <= 3'h7;
			dsp_speed_o <= 2'd2;
			dsp_clk_en_o <= 1'b0;
			gpio_pulse_o <= 4'h0;
			internal_timing_o <= 4'h0;
			deb_cnt <= 8'h00;
			pulse_f <= 1'b0;
			spd_cnt <= 2'd0;
		end else begin
			ref_resistor_port_o <= busy & rdc_port_warmup_pin[6];
			sensor_resistor_port_o <= busy & rdc_port_warmup_pin[7];
			onchip_sensor_o <= busy & rdc_port_warmup_pin[5];
			onchip_ref_resistor_o <= busy & rdc_port_warmup_pin[4];
			guard_amp_current_trim_o <= rdc_cycle_guard_trim[2:0];
			internal_timing_o <= {converter_internal_c[1], converter_internal_a[2:0]};
			dsp_speed_o <= dsp_speed_pin_routing[3:2];
			// Clock enable every 2^speed cycles for speeds 0 to 2; speed 3 also needs lfo_tick
			spd_cnt <= spd_cnt + 2'd1;
			case (dsp_speed_pin_routing[3:2])
				2'd0: dsp_clk_en_o <= 1'b1;
				2'd1: dsp_clk_en_o <= spd_cnt[0];
				2'd2: dsp_clk_en_o <= &spd_cnt;
				default: dsp_clk_en_o <= (&spd_cnt) & lfo_tick;
			endcase
			// Mono-flop holds a pulse, swallowing bounces for a fixed time
			if (pulse_debounce_enable == 2'd3) begin
				if (deb_cnt != 8'h00)
					deb_cnt <= deb_cnt - 8'h01;
				else if (dsp_q != pulse_f) begin
					pulse_f <= dsp_q;
					deb_cnt <= `RTC_DEBOUNCE_CYC;
				end
			end else begin
				pulse_f <= dsp_q;
				deb_cnt <= 8'h00;
			end
			gpio_pulse_o[3] <= pulse_f & ~pulse_route_pin_b;
			gpio_pulse_o[1] <= pulse_f & pulse_route_pin_b;
			gpio_pulse_o[2] <= pulse_f & ~pulse_route_pin_a;
			gpio_pulse_o[0] <= pulse_f & pulse_route_pin_a;
		end
	end
endmodule
`default_nettype wire

// [verilog/rtc_consts.vh]
// Register offsets, trigger source codes and timing counts of the resistance converter control block.
// Included by rtc_core.v only.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
`define RTC_IDX_CYCLE 8'h14
`define RTC_IDX_DIVLO 8'h15
`define RTC_IDX_TRIG 8'h16
`define RTC_IDX_PORT 8'h17
`define RTC_IDX_INTA 8'h18
`define RTC_IDX_INTB 8'h19
`define RTC_IDX_INTC 8'h1A
`define RTC_IDX_DSP 8'h1B
`define RTC_IDX_STATUS 8'h1C
`define RTC_TRIG_OFF 3'h0
`define RTC_TRIG_TIMER 3'h1
`define RTC_TRIG_PIN 3'h3
`define RTC_TRIG_CAP_ASYNC 3'h5
`define RTC_TRIG_CAP_SYNC 3'h6
`define RTC_LFO_DIV 16'h00FA
`define RTC_DEBOUNCE_CYC 8'h28
`define RTC_WARM_SHORT 5'h02
`define RTC_WARM_LONG 5'h08
`endif

// [tb/rtc_core_sva.sv]
// Port assertions for the converter control block.
// Bound to rtc_core below; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtc_core_sva (
	// Clock, reset and bus
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	// Converter side
	input wire logic rdc_phase_o,
	input wire logic rdc_sample_valid_o,
	input wire logic rdc_result_valid_o,
	input wire logic ref_resistor_port_o,
	input wire logic sensor_resistor_port_o,
	input wire logic onchip_sensor_o,
	input wire logic onchip_ref_resistor_o,
	input wire logic [2:0] guard_amp_current_trim_o,
	input wire logic [1:0] dsp_speed_o,
	input wire logic dsp_clk_en_o,
	input wire logic [3:0] gpio_pulse_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_wr(logic [31:0] a);
		psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
	endsequence
	AST_APB_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("bus answer late");
	AST_TRIM: assert property (s_wr(32'h50) |-> ##2 guard_amp_current_trim_o == $past(pwdata_i[2:0], 2))
		else $error("trim not taken");
	AST_SPEED: assert property (s_wr(32'h6C) |-> ##2 dsp_speed_o == $past(pwdata_i[3:2], 2))
		else $error("speed not taken");
	AST_CLK_FULL: assert property ((dsp_speed_o == 2'h0)[*3] |-> dsp_clk_en_o)
		else $error("fastest clock missed");
	AST_CLK_QUART: assert property (dsp_clk_en_o && dsp_speed_o == 2'h2 |=> (!dsp_clk_en_o || dsp_speed_o != 2'h2)[*3])
		else $error("slow clock too dense");
	AST_ROUTE_B: assert property (!(gpio_pulse_o[1] && gpio_pulse_o[3]))
		else $error("pulse on pins 1 and 3");
	AST_ROUTE_A: assert property (!(gpio_pulse_o[0] && gpio_pulse_o[2]))
		else $error("pulse on pins 0 and 2");
	AST_PORTS: assert property (ref_resistor_port_o || sensor_resistor_port_o |-> rdc_phase_o || $past(rdc_phase_o))
		else $error("port active while idle");
	AST_ONCHIP: assert property (onchip_sensor_o || onchip_ref_resistor_o |-> rdc_phase_o || $past(rdc_phase_o))
		else $error("on-chip element active while idle");
	// The last sample is flagged on the same edge that ends the measurement
	AST_SAMPLE: assert property (rdc_sample_valid_o |-> $past(rdc_phase_o))
		else $error("sample while idle");
	AST_RESULT: assert property (rdc_result_valid_o |-> rdc_sample_valid_o ##[1:2] !rdc_phase_o)
		else $error("result without last sample");
	AST_PHASE_MIN: assert property ($rose(rdc_phase_o) |-> rdc_phase_o[*8])
		else $error("measurement too short");
endmodule
bind rtc_core rtc_core_sva u_sva (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .rdc_phase_o(rdc_phase_o),
	.rdc_sample_valid_o(rdc_sample_valid_o), .rdc_result_valid_o(rdc_result_valid_o),
	.ref_resistor_port_o(ref_resistor_port_o), .sensor_resistor_port_o(sensor_resistor_port_o),
	.onchip_sensor_o(onchip_sensor_o), .onchip_ref_resistor_o(onchip_ref_resistor_o),
	.guard_amp_current_trim_o(guard_amp_current_trim_o), .dsp_speed_o(dsp_speed_o),
	.dsp_clk_en_o(dsp_clk_en_o), .gpio_pulse_o(gpio_pulse_o));
`default_nettype wire

// [tb/rtc_pin_model.sv]
// Far-side pins: trigger pins and the dsp pulse source.
// Driven by the bench through tasks; levels change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_model (
	// Clock
	input wire logic clock_i,
	// Pins
	output var logic [3:0] gpio_o,
	output var logic dsp_o
);
	initial begin
		gpio_o = 4'h0;
		dsp_o = 1'b0;
	end
	// Held for 8 cycles so the three-stage synchroniser sees it
	task automatic pin_pulse(input int p);
		@(posedge clock_i);
		gpio_o[p] <= 1'b1;
		repeat (8) @(posedge clock_i);
		gpio_o[p] <= 1'b0;
	endtask
	// A bouncing contact: short blip, short gap, then a long level
	task automatic bounce();
		@(posedge clock_i);
		dsp_o <= 1'b1;
		repeat (6) @(posedge clock_i);
		dsp_o <= 1'b0;
		repeat (6) @(posedge clock_i);
		dsp_o <= 1'b1;
		repeat (60) @(posedge clock_i);
		dsp_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/tb_rtc_core.sv]
// Self-checking bench for the converter control block.
// Drives the bus and the capacitance end event; pins come from the pin model.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_core;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic cap_done_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	wire [3:0] gpio_pin_i, gpio_pulse_o, internal_timing_o;
	wire [31:0] prdata_o;
	wire [2:0] guard_amp_current_trim_o;
	wire [1:0] dsp_speed_o;
	wire dsp_pulse_i, pready_o, pslverr_o, rdc_phase_o, rdc_sample_valid_o, rdc_result_valid_o, dsp_clk_en_o;
	wire ref_resistor_port_o, sensor_resistor_port_o, onchip_sensor_o, onchip_ref_resistor_o;
	int error_cnt = 0;
	int checks_done = 0;
	int mdl [8];
	localparam logic [7:0] reg_mask [8] = '{8'h87, 8'hFF, 8'h7F, 8'hF7, 8'h3F, 8'hFC, 8'hFE, 8'hCF};
	// Entries: source, averaging, warm-up, cycle, pre-divider
	localparam logic [19:0] tbl [5] = '{20'h00000, 20'h50002, 20'h61103, 20'h32010, 20'h13000};
	always #12.5 clock_i = ~clock_i;
	rtc_pin_model pins (.clock_i(clock_i), .gpio_o(gpio_pin_i), .dsp_o(dsp_pulse_i));
	rtc_core DUT (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .gpio_pin_i(gpio_pin_i), .cap_done_i(cap_done_i), .dsp_pulse_i(dsp_pulse_i),
		.rdc_phase_o(rdc_phase_o), .rdc_sample_valid_o(rdc_sample_valid_o), .rdc_result_valid_o(rdc_result_valid_o),
		.ref_resistor_port_o(ref_resistor_port_o), .sensor_resistor_port_o(sensor_resistor_port_o),
		.onchip_sensor_o(onchip_sensor_o), .onchip_ref_resistor_o(onchip_ref_resistor_o),
		.guard_amp_current_trim_o(guard_amp_current_trim_o), .dsp_speed_o(dsp_speed_o), .dsp_clk_en_o(dsp_clk_en_o),
		.gpio_pulse_o(gpio_pulse_o), .internal_timing_o(internal_timing_o));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Entered just after a rising edge; one idle cycle follows each transfer
	task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int i, n;
		i = int'(idx) - 20;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {22'h0, idx, 2'h0};
		pwdata_i <= {24'h0, d};
		@(posedge clock_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		check(n < 50, 1);
		check(pslverr_o, i < 0 || i > 7);
		if (!wr)
			check(prdata_o, (i >= 0 && i < 8) ? mdl[i] : 0);
		if (wr && i >= 0 && i < 8)
			mdl[i] = d & reg_mask[i];
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic meas(input int src, input int avg, input int warm, input int cyc, input int pdiv);
		int ports, pin, n, smp, dur, exp;
		ports = $urandom_range(15);
		pin = $urandom_range(3);
		acc(1, 8'h14, 8'(cyc << 7 | 7));
		acc(1, 8'h15, 8'(pdiv));
		acc(1, 8'h17, 8'(ports << 4 | warm << 2 | pin));
		acc(1, 8'h16, 8'(src << 4 | avg << 2));
		// A pulse on the neighbouring pin must not start anything
		if (src == 3) begin
			pins.pin_pulse((pin + 1) % 4);
			repeat (4) @(posedge clock_i);
			check(rdc_phase_o, 0);
		end
		// Duration counts from the start, since the first phase is cut by the free-running oscillator
		dur = 0;
		for (int k = 1; k <= pdiv || k == 1; k++) begin
			if (src == 3)
				pins.pin_pulse(pin);
			else if (src != 1) begin
				cap_done_i <= 1'b1;
				@(posedge clock_i);
				cap_done_i <= 1'b0;
			end
			repeat (20) begin
				@(posedge clock_i);
				dur += rdc_phase_o;
			end
			if (k < pdiv || src == 0)
				check(rdc_phase_o, 0);
		end
		if (src == 0)
			return;
		n = 0;
		while (rdc_phase_o !== 1'b1 && n < 300) begin
			@(posedge clock_i);
			n++;
		end
		check(n < 300, 1);
		smp = 0;
		while (rdc_result_valid_o !== 1'b1 && dur < 40000) begin
			@(posedge clock_i);
			dur++;
			smp += rdc_sample_valid_o;
			if (dur == 100)
				check({sensor_resistor_port_o, ref_resistor_port_o, onchip_sensor_o, onchip_ref_resistor_o}, ports);
		end
		exp = ((warm ? 8 : 2) + (avg ? 2 << avg : 1)) * 3 * (cyc + 1) * 250;
		check(smp, avg ? 2 << avg : 1);
		check(dur > exp - 260 && dur < exp + 260, 1);
		acc(1, 8'h16, 8'h00);
	endtask
	// Longest path is about 45000 cycles; twice that means a hang
	initial begin
		#(25 * 90000);
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [3:0] seen, prev;
		int v;
		v = $urandom(33141);
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		mdl = '{7, 0, 0, 0, 0, 0, 0, 8};
		for (int i = 0; i < 8; i++)
			acc(0, 8'(20 + i), 0);
		check(guard_amp_current_trim_o, 7);
		check(dsp_speed_o, 2);
		// Trigger source kept off so no timer start runs in the background
		for (int i = 0; i < 8; i++) begin
			acc(1, 8'(20 + i), 8'($urandom) & (i == 2 ? 8'h8F : 8'hFF));
			acc(0, 8'(20 + i), 0);
		end
		check(guard_amp_current_trim_o, mdl[0] & 7);
		check(dsp_speed_o, mdl[7] >> 2 & 3);
		acc(1, 8'h20, 8'h5A);
		acc(0, 8'h13, 0);
		acc(1, 8'h18, 8'h33);
		acc(1, 8'h19, 8'h04);
		acc(1, 8'h1A, 8'h52);
		repeat (2) @(posedge clock_i);
		check(internal_timing_o, 4'hB);
		for (int s = 0; s < 4; s++) begin
			acc(1, 8'h1B, 8'(s << 2));
			repeat (4) @(posedge clock_i);
			v = 0;
			repeat (400) begin
				@(posedge clock_i);
				v += dsp_clk_en_o;
			end
			check(s == 3 ? v <= 2 : v == 400 >> s, 1);
		end
		for (int r = 0; r < 8; r++) begin
			acc(1, 8'h1B, 8'((r > 3 ? 8'hC0 : 8'h00) | 8'h08 | r % 4));
			seen = 0;
			prev = 0;
			v = 0;
			fork
				pins.bounce();
				repeat (150) begin
					@(posedge clock_i);
					seen |= gpio_pulse_o;
					v += (gpio_pulse_o & ~prev) != 0;
					prev = gpio_pulse_o;
				end
			join
			check(seen, (r & 2 ? 4'h2 : 4'h8) | (r & 1 ? 4'h1 : 4'h4));
			check(v, r > 3 ? 1 : 2);
		end
		for (int i = 0; i < 5; i++)
			meas(tbl[i][19:16], tbl[i][15:12], tbl[i][11:8], tbl[i][7:4], tbl[i][3:0]);
		print_verdict();
	end
endmodule
`default_nettype wire
